// File: common/i2c_status_pkg.sv
package i2c_status_pkg;

    // Byte addresses of the reachable registers
    localparam logic [31:0] RX_PORT_ADDR  = 32'h8002_0800;  // Read: oldest received byte
    localparam logic [31:0] TX_PORT_ADDR  = 32'h8002_0800;  // Write: master transmit entry
    localparam logic [31:0] STS_ADDR      = 32'h8002_0804;  // Status flags
    localparam logic [31:0] CTL_ADDR      = 32'h8002_0808;  // Interrupt enables and soft reset
    localparam logic [31:0] STX_PORT_ADDR = 32'h8002_0828;  // Write: slave transmit byte

    // Status field positions
    localparam int STS_W        = 14;  // Implemented status bits
    localparam int BIT_OPC      = 0;   // Operation complete
    localparam int BIT_ARB      = 1;   // Arbitration lost
    localparam int BIT_NACK     = 2;   // Missing acknowledge
    localparam int BIT_MREQ     = 3;   // Master data request
    localparam int BIT_SREQ     = 4;   // Slave data request
    localparam int BIT_ACTIVE   = 5;   // Bus activity
    localparam int BIT_SCL      = 6;   // Clock line level
    localparam int BIT_SDA      = 7;   // Data line level
    localparam int BIT_RXFULL   = 8;   // Receive FIFO full
    localparam int BIT_RXEMPTY  = 9;   // Receive FIFO empty
    localparam int BIT_TXFULL   = 10;  // Transmit FIFO full
    localparam int BIT_TXEMPTY  = 11;  // Transmit FIFO empty
    localparam int BIT_STXFULL  = 12;  // Slave transmit FIFO full
    localparam int BIT_STXEMPTY = 13;  // Slave transmit FIFO empty
    localparam logic [13:0] STS_RESET = 14'h2A00;  // Three empty flags set

    // Control field positions
    localparam int CTL_W        = 11;  // Implemented control bits
    localparam int IE_OPC       = 0;
    localparam int IE_ARB       = 1;
    localparam int IE_NACK      = 2;
    localparam int IE_MREQ      = 3;
    localparam int IE_SREQ      = 4;
    localparam int IE_RXFULL    = 5;
    localparam int IE_RXNEMPTY  = 6;
    localparam int IE_TXNFULL   = 7;
    localparam int CTL_SWRST    = 8;
    localparam int IE_STXNFULL  = 10;
    localparam logic [10:0] CTL_RESET = 11'h000;
    localparam logic [10:0] CTL_MASK  = 11'h4FF;  // Stored enable bits

    // Entry and byte widths
    localparam int TX_ENTRY_W = 10;  // Byte plus start and stop requests
    localparam int BYTE_W     = 8;

endpackage : i2c_status_pkg

// File: logic/line_sampler.sv
// Three-stage sampler for an asynchronous line; the filtered level follows
// only once the second and third stages agree.
module line_sampler (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Raw pin level
    input  wire logic line_in,
    // Filtered level
    output logic      line_lvl
);

    logic stage1_ff;  // Metastability catcher, read only by stage2
    logic stage2_ff;  // Second stage
    logic stage3_ff;  // Third stage
    logic level_ff;   // Accepted level

    // Shift chain, idle high like a pulled-up line
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_ff <= 1'b1;
            stage2_ff <= 1'b1;
            stage3_ff <= 1'b1;
        end else begin
            stage1_ff <= line_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Accept a change only when the two later stages agree
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            level_ff <= 1'b1;
        end else if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
        end
    end

    assign line_lvl = level_ff;

endmodule // line_sampler

// File: logic/i2c_status_flags.sv
// The address-and-strobe port was left to the implementer.
module i2c_status_flags (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                sys_rst,
    // Register port
    input  wire logic [31:0]                         reg_addr,
    input  wire logic [31:0]                         reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [31:0]                         reg_rdata,
    // Two-wire bus lines
    input  wire logic                                scl_in,
    input  wire logic                                sda_in,
    output logic                                     scl_out,
    output logic                                     scl_oe,
    // Bus engine status
    input  wire logic                                engine_scl_oe,
    input  wire logic                                master_sda_oe,
    input  wire logic                                master_byte_active,
    input  wire logic                                master_mode,
    input  wire logic                                frame_open,
    input  wire logic                                last_entry_stop,
    input  wire logic                                master_drained_stop,
    input  wire logic                                missing_ack_evt,
    input  wire logic                                slave_needs_byte,
    input  wire logic                                slave_last_nacked,
    input  wire logic                                rx_byte_arrived,
    // FIFO levels
    input  wire logic                                rx_full,
    input  wire logic                                rx_empty,
    input  wire logic                                tx_full,
    input  wire logic                                tx_empty,
    input  wire logic                                stx_full,
    input  wire logic                                stx_empty,
    input  wire logic [i2c_status_pkg::BYTE_W-1:0]   rx_head,
    // FIFO controls
    output logic                                     rx_pop,
    output logic                                     tx_push,
    output logic [i2c_status_pkg::TX_ENTRY_W-1:0]    tx_push_entry,
    output logic                                     stx_push,
    output logic [i2c_status_pkg::BYTE_W-1:0]        stx_push_byte,
    output logic                                     iface_soft_reset,
    // Interrupt request
    output logic                                     irq_req
);
    import i2c_status_pkg::*;

    // Compare a bus address against one register address
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] base);
        hit = (addr == base);
    endfunction

    // Bus access decode
    logic wr_sts;      // Status write, clears the complete and arbitration flags
    logic wr_ctl;      // Control write
    logic wr_tx;       // Master transmit entry write
    logic wr_stx;      // Slave transmit byte write
    logic rd_rx;       // Receive byte read
    logic [STS_W-1:0] clr_mask;  // Ones written to the status

    assign wr_sts   = reg_wr && hit(reg_addr, STS_ADDR);
    assign wr_ctl   = reg_wr && hit(reg_addr, CTL_ADDR);
    assign wr_tx    = reg_wr && hit(reg_addr, TX_PORT_ADDR);
    assign wr_stx   = reg_wr && hit(reg_addr, STX_PORT_ADDR);
    assign rd_rx    = reg_rd && hit(reg_addr, RX_PORT_ADDR);
    assign clr_mask = wr_sts ? reg_wdata[STS_W-1:0] : '0;

    // Soft reset pulse, one cycle after the control write
    logic soft_rst_ff;

    // Control register
    logic [CTL_W-1:0] ctl_ff;  // Interrupt enables

    // Sticky event flags
    logic opc_flag_ff;                     // operation_complete_flag
    logic arbitration_lost_flag_ff;        // Arbitration lost
    logic missing_ack_flag_ff;             // No acknowledge
    logic master_data_request_flag_ff;     // Master data request
    logic slave_data_request_flag_ff;      // Slave data request
    logic active_ff;                       // Bus activity

    // Synchronised line levels and history for edges
    logic [1:0] line_raw;    // {sda, scl} pins
    logic [1:0] line_lvl;    // {sda, scl} filtered
    logic       scl_prev_ff; // Clock level one cycle ago
    logic       sda_prev_ff; // Data level one cycle ago
    logic       scl_rise;    // Clock line rising
    logic       start_det;   // Start seen on the bus
    logic       stop_det;    // Stop seen on the bus

    // Request conditions and their previous values
    logic mreq_cond;       // Master needs an entry
    logic sreq_cond;       // Slave needs a byte
    logic mreq_cond_ff;
    logic sreq_cond_ff;

    // Receive overflow clock hold
    logic rx_hold_ff;

    // Assembled status word
    logic [STS_W-1:0] sts_word;
    logic [31:0]      reg_rdata_ff;

    // Handshake and data registers toward the FIFOs
    logic                  tx_push_ff;
    logic [TX_ENTRY_W-1:0] tx_entry_ff;
    logic                  stx_push_ff;
    logic [BYTE_W-1:0]     stx_byte_ff;

    assign line_raw = {sda_in, scl_in};

    // Sample both lines into the system clock domain
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            line_sampler u_sampler (
                .clk_sys  (clk_sys),
                .sys_rst  (sys_rst),
                .line_in  (line_raw[gi]),
                .line_lvl (line_lvl[gi])
            );
        end
    endgenerate

    // Line history for edge finding
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= line_lvl[0];
            sda_prev_ff <= line_lvl[1];
        end
    end

    // Start: data falls while clock stays high; stop: data rises
    assign scl_rise  = line_lvl[0] && !scl_prev_ff;
    assign start_det = line_lvl[0] && scl_prev_ff && sda_prev_ff && !line_lvl[1];
    assign stop_det  = line_lvl[0] && scl_prev_ff && !sda_prev_ff && line_lvl[1];

    // Request conditions; flags fire on their rising edge so a write that
    // has not yet reached the FIFO does not immediately re-raise them
    assign mreq_cond = tx_empty && master_mode && frame_open && !last_entry_stop;
    assign sreq_cond = stx_empty && slave_needs_byte && !slave_last_nacked;

    // Condition history
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mreq_cond_ff <= 1'b0;
            sreq_cond_ff <= 1'b0;
        end else begin
            mreq_cond_ff <= mreq_cond;
            sreq_cond_ff <= sreq_cond;
        end
    end

    // Control register; soft reset bit does not store
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_ff <= CTL_RESET;
        end else if (wr_ctl) begin
            ctl_ff <= reg_wdata[CTL_W-1:0] & CTL_MASK;
        end
    end

    // Soft reset strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_ctl && reg_wdata[CTL_SWRST];
        end
    end

    // Operation complete; a set in the clearing cycle wins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            opc_flag_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            opc_flag_ff <= 1'b0;
        end else if (master_drained_stop) begin
            opc_flag_ff <= 1'b1;
        end else if (clr_mask[BIT_OPC]) begin
            opc_flag_ff <= 1'b0;
        end
    end

    // Arbitration lost: released one bit read back low at clock rise
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            arbitration_lost_flag_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            arbitration_lost_flag_ff <= 1'b0;
        end else if (master_byte_active && !master_sda_oe && scl_rise && !line_lvl[1]) begin
            arbitration_lost_flag_ff <= 1'b1;
        end else if (clr_mask[BIT_ARB]) begin
            arbitration_lost_flag_ff <= 1'b0;
        end
    end

    // Missing acknowledge: cleared by a new transmit entry
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            missing_ack_flag_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            missing_ack_flag_ff <= 1'b0;
        end else if (missing_ack_evt) begin
            missing_ack_flag_ff <= 1'b1;
        end else if (wr_tx) begin
            missing_ack_flag_ff <= 1'b0;
        end
    end

    // Master data request
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            master_data_request_flag_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            master_data_request_flag_ff <= 1'b0;
        end else if (mreq_cond && !mreq_cond_ff) begin
            master_data_request_flag_ff <= 1'b1;
        end else if (wr_tx) begin
            master_data_request_flag_ff <= 1'b0;
        end
    end

    // Slave data request
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slave_data_request_flag_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            slave_data_request_flag_ff <= 1'b0;
        end else if (sreq_cond && !sreq_cond_ff) begin
            slave_data_request_flag_ff <= 1'b1;
        end else if (wr_stx) begin
            slave_data_request_flag_ff <= 1'b0;
        end
    end

    // Bus activity between start and stop
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            active_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            active_ff <= 1'b0;
        end else if (start_det) begin
            active_ff <= 1'b1;
        end else if (stop_det) begin
            active_ff <= 1'b0;
        end
    end

    // Overflow interlock: hold the clock low until software reads a byte
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_hold_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            rx_hold_ff <= 1'b0;
        end else if (rx_full && rx_byte_arrived) begin
            rx_hold_ff <= 1'b1;
        end else if (rd_rx) begin
            rx_hold_ff <= 1'b0;
        end
    end

    // Status word; FIFO flags come live from the FIFOs
    always_comb begin
        sts_word               = '0;
        sts_word[BIT_OPC]      = opc_flag_ff;
        sts_word[BIT_ARB]      = arbitration_lost_flag_ff;
        sts_word[BIT_NACK]     = missing_ack_flag_ff;
        sts_word[BIT_MREQ]     = master_data_request_flag_ff;
        sts_word[BIT_SREQ]     = slave_data_request_flag_ff;
        sts_word[BIT_ACTIVE]   = active_ff;
        sts_word[BIT_SCL]      = line_lvl[0];
        sts_word[BIT_SDA]      = line_lvl[1];
        sts_word[BIT_RXFULL]   = rx_full;
        sts_word[BIT_RXEMPTY]  = rx_empty;
        sts_word[BIT_TXFULL]   = tx_full;
        sts_word[BIT_TXEMPTY]  = tx_empty;
        sts_word[BIT_STXFULL]  = stx_full;
        sts_word[BIT_STXEMPTY] = stx_empty;
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_ff <= '0;
        end else if (!reg_rd) begin
            reg_rdata_ff <= '0;
        end else if (hit(reg_addr, STS_ADDR)) begin
            reg_rdata_ff <= {{(32-STS_W){1'b0}}, sts_word};      // Reserved bits read zero
        end else if (hit(reg_addr, CTL_ADDR)) begin
            reg_rdata_ff <= {{(32-CTL_W){1'b0}}, ctl_ff};
        end else if (hit(reg_addr, RX_PORT_ADDR)) begin
            reg_rdata_ff <= {{(32-BYTE_W){1'b0}}, rx_head};
        end else begin
            reg_rdata_ff <= '0;                                  // Unmapped
        end
    end

    // Registered pushes toward the transmit FIFOs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_push_ff  <= 1'b0;
            tx_entry_ff <= '0;
            stx_push_ff <= 1'b0;
            stx_byte_ff <= '0;
        end else begin
            tx_push_ff  <= wr_tx;
            stx_push_ff <= wr_stx;
            if (wr_tx) begin
                tx_entry_ff <= reg_wdata[TX_ENTRY_W-1:0];
            end
            if (wr_stx) begin
                stx_byte_ff <= reg_wdata[BYTE_W-1:0];
            end
        end
    end

    // Interrupt request from enabled flags and FIFO conditions
    assign irq_req = (ctl_ff[IE_OPC]      && opc_flag_ff)                 ||
                     (ctl_ff[IE_ARB]      && arbitration_lost_flag_ff)    ||
                     (ctl_ff[IE_NACK]     && missing_ack_flag_ff)         ||
                     (ctl_ff[IE_MREQ]     && master_data_request_flag_ff) ||
                     (ctl_ff[IE_SREQ]     && slave_data_request_flag_ff)  ||
                     (ctl_ff[IE_RXFULL]   && rx_full)                     ||
                     (ctl_ff[IE_RXNEMPTY] && !rx_empty)                   ||
                     (ctl_ff[IE_TXNFULL]  && !tx_full)                    ||
                     (ctl_ff[IE_STXNFULL] && !stx_full);

    // Output drive
    assign reg_rdata        = reg_rdata_ff;
    assign scl_out          = 1'b0;                              // Open drain, only pulls low
    assign scl_oe           = engine_scl_oe || rx_hold_ff;
    assign rx_pop           = rd_rx;                             // Pop in the read cycle
    assign tx_push          = tx_push_ff;
    assign tx_push_entry    = tx_entry_ff;
    assign stx_push         = stx_push_ff;
    assign stx_push_byte    = stx_byte_ff;
    assign iface_soft_reset = soft_rst_ff;

endmodule // i2c_status_flags

// File: tb/i2c_status_flags_properties.sv
module i2c_status_props
    import i2c_status_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    // Register port
    input wire logic [31:0]           reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    // Clock line drive and engine request
    input wire logic                  scl_out,
    input wire logic                  scl_oe,
    input wire logic                  engine_scl_oe,
    // FIFO side
    input wire logic                  rx_byte_arrived,
    input wire logic                  rx_full,
    input wire logic                  rx_empty,
    input wire logic                  tx_full,
    input wire logic                  tx_empty,
    input wire logic                  stx_full,
    input wire logic                  stx_empty,
    input wire logic                  rx_pop,
    input wire logic                  tx_push,
    input wire logic [TX_ENTRY_W-1:0] tx_push_entry,
    input wire logic                  stx_push,
    input wire logic [BYTE_W-1:0]     stx_push_byte,
    input wire logic                  iface_soft_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Read strobe aimed at the receive port
    wire logic rx_rd = reg_rd && reg_addr == RX_PORT_ADDR;

    idle_rdata_a:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data not idle");
    status_live_a:
        assert property (reg_rd && reg_addr == STS_ADDR |=> reg_rdata[31:8] == {18'h0_0000,
            $past({stx_empty, stx_full, tx_empty, tx_full, rx_empty, rx_full})}) else $error("fifo flags wrong");
    pop_match_a:
        assert property (rx_pop == rx_rd) else $error("rx pop mismatch");
    tx_push_a:
        assert property (reg_wr && reg_addr == TX_PORT_ADDR |=> tx_push && tx_push_entry == $past(reg_wdata[9:0]))
            else $error("tx push wrong");
    stx_push_a:
        assert property (reg_wr && reg_addr == STX_PORT_ADDR |=> stx_push && stx_push_byte == $past(reg_wdata[7:0]))
            else $error("slave push wrong");
    hold_set_a:
        assert property (rx_full && rx_byte_arrived && !iface_soft_reset |=> scl_oe) else $error("no clock hold");
    hold_release_a:
        assert property (rx_rd && !rx_byte_arrived ##1 !engine_scl_oe |-> !scl_oe) else $error("hold not released");
    engine_pass_a:
        assert property (engine_scl_oe |-> scl_oe && scl_out == 1'b0) else $error("engine pull lost");
    soft_pulse_a:
        assert property (reg_wr && reg_addr == CTL_ADDR && reg_wdata[CTL_SWRST] |=> iface_soft_reset ##1
            !iface_soft_reset) else $error("soft reset pulse wrong");

    // Main scenarios reached
    cover property (scl_oe && !engine_scl_oe);
    cover property (iface_soft_reset);
    cover property (rx_pop ##1 !scl_oe);
endmodule // i2c_status_props

bind i2c_status_flags i2c_status_props u_i2c_status_props (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .scl_out, .scl_oe, .engine_scl_oe, .rx_byte_arrived, .rx_full, .rx_empty, .tx_full,
    .tx_empty, .stx_full, .stx_empty, .rx_pop, .tx_push, .tx_push_entry, .stx_push, .stx_push_byte,
    .iface_soft_reset);

// File: tb/bus_partner.sv
module bus_partner (
    // Pull-low requests from the device side
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    // Resolved line levels
    output logic      scl_line,
    output logic      sda_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_low = 1'b0;  // Partner pulls clock low
    logic sda_low = 1'b0;  // Partner pulls data low
    // Pull-ups: a line is high unless some party pulls it low
    assign scl_line = !(scl_low || scl_oe);
    assign sda_line = !(sda_low || sda_oe);
    // Start: data falls while clock is high
    task automatic start_cond();
        sda_low = 1'b1;
        #400 scl_low = 1'b1;
        #400;
    endtask
    // One bit: data moves while clock is low, then clock rises and stays
    task automatic put_bit(input logic b);
        scl_low = 1'b1;
        #200 sda_low = !b;
        #200 scl_low = 1'b0;
        #400;
    endtask
    // Stop: clock rises first, then data; clock stands still afterwards
    task automatic stop_cond();
        scl_low = 1'b1;
        #400 sda_low = 1'b1;
        #400 scl_low = 1'b0;
        #400 sda_low = 1'b0;
        #400;
    endtask
endmodule // bus_partner

// File: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_status_pkg::*;
    // Stimulus and observed signals
    logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, scl_in, sda_in, scl_out, scl_oe;
    logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic engine_scl_oe = 0, master_sda_oe = 0, master_byte_active = 0, master_mode = 0, frame_open = 0;
    logic last_entry_stop = 0, master_drained_stop = 0, missing_ack_evt = 0, slave_needs_byte = 0;
    logic slave_last_nacked = 0, rx_byte_arrived = 0, rx_full = 0, rx_empty = 1, tx_full = 0, tx_empty = 1;
    logic stx_full = 0, stx_empty = 1, rx_pop, tx_push, stx_push, iface_soft_reset, irq_req;
    logic [7:0] rx_head = 0, stx_push_byte;
    logic [9:0] tx_push_entry;
    int bad_count = 0, compares = 0, cycles = 0;
    localparam logic [31:0] S0 = 32'h0000_2AC0;  // Idle status, both lines high

    i2c_status_flags u_i2c_status_flags (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .scl_in, .sda_in, .scl_out, .scl_oe, .engine_scl_oe, .master_sda_oe, .master_byte_active, .master_mode,
        .frame_open, .last_entry_stop, .master_drained_stop, .missing_ack_evt, .slave_needs_byte,
        .slave_last_nacked, .rx_byte_arrived, .rx_full, .rx_empty, .tx_full, .tx_empty, .stx_full, .stx_empty,
        .rx_head, .rx_pop, .tx_push, .tx_push_entry, .stx_push, .stx_push_byte, .iface_soft_reset, .irq_req);
    bus_partner u_bus_partner (.scl_oe(scl_oe), .sda_oe(master_sda_oe), .scl_line(scl_in), .sda_line(sda_in));

    // 100 ns system clock
    initial begin
        forever #50 clk_sys = !clk_sys;
    end
    // Compare and count
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [31:0] a, string what, logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        tick(2);
        sys_rst <= 0;
        rd(STS_ADDR, "reset status", S0);
        rd(32'h8002_0830, "unmapped", 32'h0000_0000);
        @(posedge clk_sys) {missing_ack_evt, master_drained_stop} <= 2'b11;
        @(posedge clk_sys) {missing_ack_evt, master_drained_stop} <= 2'b00;
        rd(STS_ADDR, "events", S0 | 32'h0000_0005);
        wr(STS_ADDR, 32'h0000_3FFE);
        rd(STS_ADDR, "zero keeps", S0 | 32'h0000_0005);
        wr(STS_ADDR, 32'h0000_0001);
        rd(STS_ADDR, "one clears", S0 | 32'h0000_0004);
        wr(TX_PORT_ADDR, 32'h0000_0355);
        rd(STS_ADDR, "nack cleared", S0);
        $display("test flag clearing done");
        u_bus_partner.start_cond();
        @(posedge clk_sys) master_byte_active <= 1;
        u_bus_partner.put_bit(1'b0);
        tick(8);
        master_byte_active <= 0;
        rd(STS_ADDR, "arb and active", 32'h0000_2A62);
        u_bus_partner.stop_cond();
        tick(8);
        rd(STS_ADDR, "stop", 32'h0000_2AC2);
        wr(STS_ADDR, 32'h0000_0002);
        rd(STS_ADDR, "arb cleared", S0);
        $display("test bus events done");
        @(posedge clk_sys) {master_mode, frame_open, last_entry_stop} <= 3'b111;
        tick(3);
        rd(STS_ADDR, "no request after stop", S0);
        @(posedge clk_sys) last_entry_stop <= 0;
        tick(3);
        rd(STS_ADDR, "master request", S0 | 32'h0000_0008);
        wr(TX_PORT_ADDR, 32'h0000_0100);
        rd(STS_ADDR, "master served", S0);
        @(posedge clk_sys) {master_mode, frame_open, slave_needs_byte, slave_last_nacked} <= 4'b0011;
        tick(3);
        rd(STS_ADDR, "no request after nack", S0);
        @(posedge clk_sys) slave_last_nacked <= 0;
        tick(3);
        rd(STS_ADDR, "slave request", S0 | 32'h0000_0010);
        wr(STX_PORT_ADDR, 32'h0000_005A);
        rd(STS_ADDR, "slave served", S0);
        @(posedge clk_sys) slave_needs_byte <= 0;
        $display("test requests done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys) {stx_empty, stx_full, tx_empty, tx_full, rx_empty, rx_full} <= 6'(1 << i);
            rd(STS_ADDR, "fifo flags", 32'h0000_00C0 | (32'h0000_0100 << i));
        end
        @(posedge clk_sys) {stx_empty, stx_full, tx_empty, tx_full, rx_empty, rx_full} <= 6'b10_1010;
        {engine_scl_oe, rx_head} <= {1'b1, 8'hA5};
        tick(8);
        rd(STS_ADDR, "clock low seen", 32'h0000_2A80);
        @(posedge clk_sys) {engine_scl_oe, rx_full, rx_empty, rx_byte_arrived} <= 4'b0101;
        @(posedge clk_sys) rx_byte_arrived <= 0;
        tick(8);
        chk("overflow hold", 32'(scl_oe), 32'h0000_0001);
        rd(STS_ADDR, "full and held", 32'h0000_2980);
        rd(RX_PORT_ADDR, "rx byte", 32'h0000_00A5);
        chk("hold released", 32'(scl_oe), 32'h0000_0000);
        @(posedge clk_sys) {rx_full, rx_empty} <= 2'b01;
        $display("test fifo flags done");
        wr(CTL_ADDR, 32'h0000_0004);
        rd(CTL_ADDR, "enables", 32'h0000_0004);
        chk("irq idle", 32'(irq_req), 32'h0000_0000);
        @(posedge clk_sys) {missing_ack_evt, master_drained_stop} <= 2'b11;
        @(posedge clk_sys) {missing_ack_evt, master_drained_stop} <= 2'b00;
        #1 chk("irq raised", 32'(irq_req), 32'h0000_0001);
        wr(CTL_ADDR, 32'h0000_0104);
        rd(STS_ADDR, "soft reset", S0);
        chk("irq after soft reset", 32'(irq_req), 32'h0000_0000);
        rd(CTL_ADDR, "enables kept", 32'h0000_0004);
        wr(CTL_ADDR, 32'h0000_0000);
        $display("test interrupt and soft reset done");
        summarize();
    end
endmodule // testbench
